// File: design/fbc_defines.svh
// Constants for the flash bus host controller.
// Assumes a 10 MHz clock; included by its bare name.
`ifndef FBC_DEFINES_SVH
`define FBC_DEFINES_SVH

`define FBC_CLK_NS        100
`define FBC_STROBE_NS     200
`define FBC_STROBE_CYC    ((`FBC_STROBE_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_SYNC_CYC      3
`define FBC_READ_CYC      (`FBC_STROBE_CYC + `FBC_SYNC_CYC)
`define FBC_CMD_READ_ARR  8'hFF
`define FBC_CMD_READ_ID   8'h90
`define FBC_CMD_READ_STAT 8'h70
`define FBC_CMD_CLR_STAT  8'h50
`define FBC_CMD_PROG      8'h40
`define FBC_CMD_ERASE     8'h20
`define FBC_CMD_CONFIRM   8'hD0
`define FBC_CMD_SUSPEND   8'hB0
`define FBC_READY_BIT     7

`endif

// File: design/fbc_pkg.sv
// Types for the flash bus host controller.
// Assumes nothing of its surroundings.
package fbc_pkg;
  typedef enum logic [5:0] {
    FBC_IDLE   = 6'h01,
    FBC_SETUP  = 6'h02,
    FBC_STROBE = 6'h04,
    FBC_HOLD   = 6'h08,
    FBC_SECOND = 6'h10,
    FBC_DONE   = 6'h20
  } fbc_state_e;

  typedef enum logic [1:0] {
    FBC_OP_READ  = 2'h0,
    FBC_OP_WRITE = 2'h1,
    FBC_OP_PROG  = 2'h2,
    FBC_OP_ERASE = 2'h3
  } fbc_op_e;
endpackage

// File: design/fbc_host.sv
// Host-side controller driving a parallel boot-block flash by its pins.
// Assumes a user port giving one request at a time and a device on pins.
`timescale 1ns/100ps
`include "fbc_defines.svh"

module fbc_host (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [1:0]  req_op,
  input  wire logic [16:0] req_addr,
  input  wire logic [15:0] req_data,
  input  wire logic        req_boot,
  input  wire logic        word_mode,
  input  wire logic        supply_ok,
  input  wire logic        sleep_req,
  input  wire logic        boot_unlock,
  output logic             resp_valid,
  output logic [15:0]      resp_data,
  output logic             resp_refused,
  output logic             deep_sleep_reset_n,
  output logic             unlock_high_level,
  output logic             chip_sel_n,
  output logic             read_en_n,
  output logic             write_en_n,
  output logic             width_word,
  output logic [16:0]      addr,
  output logic [15:0]      dq_out,
  output logic [15:0]      dq_oe,
  input  wire logic [15:0] dq_in
);

  // ---------------------------------------------------------------
  // Pin input synchroniser
  // ---------------------------------------------------------------
  logic [15:0] dq_s1, dq_s2, dq_s3, dq_sync;
  logic [15:0] next_dq_sync;

  always_comb begin
    next_dq_sync = (dq_s2 == dq_s3) ? dq_s3 : dq_sync;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1   <= 16'h0000;
      dq_s2   <= 16'h0000;
      dq_s3   <= 16'h0000;
      dq_sync <= 16'h0000;
    end else begin
      dq_s1   <= dq_in;
      dq_s2   <= dq_s1;
      dq_s3   <= dq_s2;
      dq_sync <= next_dq_sync;
    end
  end

  // ---------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------
  fbc_pkg::fbc_state_e state, next_state;
  logic [3:0]  cnt, next_cnt;
  logic [1:0]  op, next_op;
  logic [16:0] a_q, next_a_q;
  logic [15:0] d_q, next_d_q;
  logic        boot_q, next_boot_q;
  logic        wmode_q, next_wmode_q;
  logic        second, next_second;
  logic        resp_v, next_resp_v;
  logic [15:0] rdata, next_rdata;
  logic        refused, next_refused;
  // Program data kept for the second write
  logic [15:0] req_data_hold, next_req_data_hold;

  function automatic logic [7:0] first_cmd(input logic [1:0] o);
    case (o)
      fbc_pkg::FBC_OP_PROG:  first_cmd = `FBC_CMD_PROG;
      fbc_pkg::FBC_OP_ERASE: first_cmd = `FBC_CMD_ERASE;
      default:               first_cmd = 8'h00;
    endcase
  endfunction

  logic two_cycle;
  logic needs_unlock_bad;
  logic busy_read_win;
  assign two_cycle = (req_op == fbc_pkg::FBC_OP_PROG) ||
                     (req_op == fbc_pkg::FBC_OP_ERASE);
  assign needs_unlock_bad = req_boot && !boot_unlock;
  assign busy_read_win = (state == fbc_pkg::FBC_STROBE) &&
                         (op == fbc_pkg::FBC_OP_READ);

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_op      = op;
    next_a_q     = a_q;
    next_d_q     = d_q;
    next_boot_q  = boot_q;
    next_wmode_q = wmode_q;
    next_second  = second;
    next_resp_v  = 1'b0;
    next_rdata   = rdata;
    next_refused = 1'b0;
    next_req_data_hold = req_data_hold;
    case (state)
      fbc_pkg::FBC_IDLE: begin
        if (req_valid && !sleep_req) begin
          if (two_cycle && (!supply_ok || needs_unlock_bad)) begin
            next_resp_v  = 1'b1;
            next_refused = 1'b1;
          end else begin
            next_state   = fbc_pkg::FBC_SETUP;
            next_op      = req_op;
            next_a_q     = req_addr;
            next_d_q     = two_cycle ? {8'h00, first_cmd(req_op)}
                                     : req_data;
            next_boot_q  = req_boot;
            next_wmode_q = word_mode;
            next_second  = 1'b0;
            next_req_data_hold = req_data;
          end
        end
      end
      fbc_pkg::FBC_SETUP: begin
        next_state = fbc_pkg::FBC_STROBE;
        // Reads hold the strobe until the synchroniser has settled
        next_cnt   = (op == fbc_pkg::FBC_OP_READ) ? 4'(`FBC_READ_CYC)
                                                  : 4'(`FBC_STROBE_CYC);
      end
      fbc_pkg::FBC_STROBE: begin
        if (cnt > 4'h1) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_state = fbc_pkg::FBC_HOLD;
          if (op == fbc_pkg::FBC_OP_READ) begin
            // byte width keeps only the low lane
            next_rdata = wmode_q ? dq_sync : {8'h00, dq_sync[7:0]};
          end
        end
      end
      fbc_pkg::FBC_HOLD: begin
        if ((op == fbc_pkg::FBC_OP_PROG || op == fbc_pkg::FBC_OP_ERASE)
            && !second) begin
          next_state  = fbc_pkg::FBC_SETUP;
          next_second = 1'b1;
          next_d_q    = (op == fbc_pkg::FBC_OP_ERASE)
                        ? {8'h00, `FBC_CMD_CONFIRM} : req_data_hold;
        end else begin
          next_state  = fbc_pkg::FBC_DONE;
        end
      end
      fbc_pkg::FBC_DONE: begin
        next_state  = fbc_pkg::FBC_IDLE;
        next_resp_v = 1'b1;
      end
      default: next_state = fbc_pkg::FBC_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state         <= fbc_pkg::FBC_IDLE;
      cnt           <= 4'h0;
      op            <= 2'h0;
      a_q           <= 17'h00000;
      d_q           <= 16'h0000;
      boot_q        <= 1'b0;
      wmode_q       <= 1'b1;
      second        <= 1'b0;
      resp_v        <= 1'b0;
      rdata         <= 16'h0000;
      refused       <= 1'b0;
      req_data_hold <= 16'h0000;
    end else begin
      state         <= next_state;
      cnt           <= next_cnt;
      op            <= next_op;
      a_q           <= next_a_q;
      d_q           <= next_d_q;
      boot_q        <= next_boot_q;
      wmode_q       <= next_wmode_q;
      second        <= next_second;
      resp_v        <= next_resp_v;
      rdata         <= next_rdata;
      refused       <= next_refused;
      req_data_hold <= next_req_data_hold;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic is_write;
  logic active;
  assign is_write = (op != fbc_pkg::FBC_OP_READ);
  assign active   = (state == fbc_pkg::FBC_SETUP) ||
                    (state == fbc_pkg::FBC_STROBE) ||
                    (state == fbc_pkg::FBC_HOLD);

  assign req_ready          = (state == fbc_pkg::FBC_IDLE) && !sleep_req;
  assign resp_valid         = resp_v;
  assign resp_data          = rdata;
  assign resp_refused       = refused;
  assign deep_sleep_reset_n = !(sleep_req && state == fbc_pkg::FBC_IDLE);
  assign unlock_high_level  = boot_q && boot_unlock && is_write;
  assign chip_sel_n         = !active;
  assign read_en_n          = !busy_read_win;
  assign write_en_n         = !(state == fbc_pkg::FBC_STROBE && is_write);
  assign width_word         = wmode_q;
  assign addr               = a_q;
  assign dq_out             = d_q;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_oe
      // upper lanes never driven in byte width
      assign dq_oe[gi] = active && is_write && (wmode_q || gi < 8);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_no_contention;
    @(posedge clock) disable iff (!rst_n)
      !read_en_n |-> (dq_oe == 16'h0000) && !chip_sel_n && write_en_n;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("read strobe while host drives data");

  property p_write_shape;
    @(posedge clock) disable iff (!rst_n)
      !write_en_n |-> read_en_n && !chip_sel_n && deep_sleep_reset_n;
  endproperty
  a_write_shape: assert property (p_write_shape)
    else $error("write strobe without select");

  property p_byte_lanes;
    @(posedge clock) disable iff (!rst_n)
      !width_word |-> dq_oe[15:8] == 8'h00;
  endproperty
  a_byte_lanes: assert property (p_byte_lanes)
    else $error("upper lanes driven in byte width");

  property p_idle_deselect;
    @(posedge clock) disable iff (!rst_n)
      state == fbc_pkg::FBC_IDLE |-> chip_sel_n && read_en_n;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect)
    else $error("chip selected while idle");

  property p_supply_refuse;
    @(posedge clock) disable iff (!rst_n)
      state == fbc_pkg::FBC_IDLE && req_valid && !sleep_req && two_cycle
      && !supply_ok |=> resp_refused && resp_valid
      && state == fbc_pkg::FBC_IDLE;
  endproperty
  a_supply_refuse: assert property (p_supply_refuse)
    else $error("program without supply not refused");

  property p_boot_refuse;
    @(posedge clock) disable iff (!rst_n)
      state == fbc_pkg::FBC_IDLE && req_valid && !sleep_req && two_cycle
      && req_boot && !boot_unlock |=> resp_refused;
  endproperty
  a_boot_refuse: assert property (p_boot_refuse)
    else $error("boot write without unlock not refused");

  property p_two_writes;
    @(posedge clock) disable iff (!rst_n)
      $rose(second) |-> $past(dq_out[7:0]) == `FBC_CMD_PROG
      || $past(dq_out[7:0]) == `FBC_CMD_ERASE;
  endproperty
  a_two_writes: assert property (p_two_writes)
    else $error("second write without set-up command");

  property p_strobe_len;
    @(posedge clock) disable iff (!rst_n)
      $fell(write_en_n) |-> !write_en_n [*2] ##1 write_en_n;
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("write strobe length wrong");

  c_read:   cover property (@(posedge clock) $fell(read_en_n));
  c_prog:   cover property (@(posedge clock)
                           $rose(second) && op == fbc_pkg::FBC_OP_PROG);
  c_erase:  cover property (@(posedge clock)
                           $rose(second) && op == fbc_pkg::FBC_OP_ERASE);
  c_refuse: cover property (@(posedge clock) resp_refused);

endmodule

// File: sim/fbc_flash_model.sv
// Behavioural flash device on the host controller's pins.
// Assumes strobes come from the host; no clock of its own.
`timescale 1ns/100ps
`include "fbc_defines.svh"

module fbc_flash_model #(
  parameter logic [15:0] MFR_ID = 16'h00C3, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h4D2E, // Arbitrary value
  parameter logic [16:0] PRE_A  = 17'h00005,
  parameter logic [15:0] PRE_D  = 16'h3C5A
) (
  input  wire logic        deep_sleep_reset_n,
  input  wire logic        unlock_high_level,
  input  wire logic        chip_sel_n,
  input  wire logic        read_en_n,
  input  wire logic        write_en_n,
  input  wire logic        width_word,
  input  wire logic [16:0] addr,
  input  wire logic [15:0] dq_out,
  input  wire logic [15:0] dq_oe,
  output logic      [15:0] dq_in
);
  logic [15:0] mem [int];
  logic [1:0]  mode = 2'h0; // 0 array, 1 identifier, 2 status
  logic        prog = 1'b0;
  logic        ers  = 1'b0;
  logic [15:0] rdat;
  logic [15:0] drv;
  logic [15:0] flt  = 16'h5A5A;
  logic        bok;
  int          a;

  // ------------------------------
  // Read path and command decoder
  // ------------------------------
  initial mem[PRE_A] = PRE_D;
  always #50 flt = ~flt; // Floating lines keep no value
  assign a = int'(addr);
  assign bok = addr[16:13] != 4'hF || unlock_high_level;
  always @* begin
    case (mode)
      2'h1: rdat = addr[0] ? DEV_ID : MFR_ID;
      2'h2: rdat = 16'h0001 << `FBC_READY_BIT;
      default: rdat = mem.exists(a) ? mem[a] : 16'hFFFF;
    endcase
  end
  assign drv = !deep_sleep_reset_n || chip_sel_n || read_en_n
    || !write_en_n ? 16'h0000 : width_word ? 16'hFFFF : 16'h00FF;
  assign dq_in = dq_oe & dq_out | ~dq_oe & (drv & rdat | ~drv & flt);

  always @(posedge write_en_n or negedge deep_sleep_reset_n) begin
    if (!deep_sleep_reset_n) begin
      mode = 2'h0;
      prog = 1'b0;
      ers = 1'b0;
    end else if (!chip_sel_n && read_en_n) begin
      if (prog) begin
        if (bok)
          mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & dq_in;
        prog = 1'b0;
        mode = 2'h2;
      end else if (ers) begin
        // Single-block array: erase clears it all
        if (bok && dq_in[7:0] == `FBC_CMD_CONFIRM)
          mem.delete();
        ers = 1'b0;
        mode = 2'h2;
      end else begin
        case (dq_in[7:0])
          `FBC_CMD_READ_ARR:  mode = 2'h0;
          `FBC_CMD_READ_ID:   mode = 2'h1;
          `FBC_CMD_READ_STAT: mode = 2'h2;
          `FBC_CMD_PROG:      prog = 1'b1;
          `FBC_CMD_ERASE:     ers = 1'b1;
          default: ;
        endcase
      end
    end
  end
endmodule

// File: sim/fbc_host_tb.sv
// Self-checking bench for the flash bus host controller.
// Assumes fbc_flash_model on the device pins.
`timescale 1ns/100ps
`include "fbc_defines.svh"

module fbc_host_tb;
  localparam logic [16:0] PA = 17'h00005;
  localparam logic [15:0] PD = 16'h3C5A;
  localparam logic [15:0] MF = 16'h00C3; // Arbitrary value
  localparam logic [15:0] DV = 16'h4D2E; // Arbitrary value
  localparam logic [15:0] ST = 16'h0001 << `FBC_READY_BIT;

  logic        clock = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
  logic [1:0]  req_op = 2'h0;
  logic [16:0] req_addr = 17'h00000;
  logic [15:0] req_data = 16'h0000;
  logic        req_boot = 1'b0, word_mode = 1'b1, supply_ok = 1'b1;
  logic        sleep_req = 1'b0, boot_unlock = 1'b0;
  logic        req_ready, resp_valid, resp_refused, deep_sleep_reset_n;
  logic        unlock_high_level, chip_sel_n, read_en_n, write_en_n;
  logic        width_word;
  logic [16:0] addr;
  logic [15:0] resp_data, dq_out, dq_oe, dq_in, rd, lat;
  logic        rf;
  int          error_cnt = 0;
  int          total_checks = 0;

  fbc_host u_dut (.clock, .rst_n, .req_valid, .req_ready, .req_op,
    .req_addr, .req_data, .req_boot, .word_mode, .supply_ok, .sleep_req,
    .boot_unlock, .resp_valid, .resp_data, .resp_refused,
    .deep_sleep_reset_n, .unlock_high_level, .chip_sel_n, .read_en_n,
    .write_en_n, .width_word, .addr, .dq_out, .dq_oe, .dq_in);
  fbc_flash_model #(.MFR_ID(MF), .DEV_ID(DV), .PRE_A(PA), .PRE_D(PD))
    u_dev (.deep_sleep_reset_n, .unlock_high_level, .chip_sel_n,
    .read_en_n, .write_en_n, .width_word, .addr, .dq_out, .dq_oe, .dq_in);

  always #50 clock = ~clock;

  // ------------------------------
  // Shared tasks and scenarios
  // ------------------------------
  task automatic check(input string nm, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_req(input logic [1:0] op, input logic [16:0] a,
                        input logic [15:0] d, input logic b);
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_boot <= b;
    #1;
    check("ready", {15'h0000, req_ready}, 16'h0001);
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    lat = 16'h0001;
    repeat (20) begin
      if (resp_valid !== 1'b1) begin
        @(posedge clock);
        #1;
        lat++;
      end
    end
    if (resp_valid !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    rd = resp_data;
    rf = resp_refused;
  endtask

  task automatic wr(input logic [7:0] c);
    do_req(fbc_pkg::FBC_OP_WRITE, 17'h00000, {8'h00, c}, 1'b0);
  endtask

  task automatic rdc(input string nm, input logic [16:0] a,
                     input logic [15:0] e);
    do_req(fbc_pkg::FBC_OP_READ, a, 16'h0000, 1'b0);
    check(nm, rd, e);
  endtask

  task automatic t_ident;
    wr(`FBC_CMD_READ_ID);
    rdc("mfr", 17'h00000, MF);
    rdc("dev", 17'h1FFFF, DV);
    @(posedge clock) word_mode <= 1'b0;
    rdc("byte dev", 17'h00001, {8'h00, DV[7:0]});
    @(posedge clock) word_mode <= 1'b1;
    wr(`FBC_CMD_READ_ARR);
    rdc("back", PA, PD);
  endtask

  task automatic t_sleep;
    wr(`FBC_CMD_READ_ID);
    @(posedge clock) sleep_req <= 1'b1;
    @(posedge clock);
    #1;
    check("sleep pin", {15'h0000, deep_sleep_reset_n}, 16'h0000);
    check("sleep oe", dq_oe, 16'h0000);
    @(posedge clock) sleep_req <= 1'b0;
    rdc("wake", PA, PD);
  endtask

  task automatic t_prog;
    do_req(fbc_pkg::FBC_OP_PROG, 17'h00020, 16'h0F0F, 1'b0);
    check("prog lat", lat, 16'h000A);
    rdc("status", 17'h00020, ST);
    @(posedge clock) boot_unlock <= 1'b1;
    do_req(fbc_pkg::FBC_OP_PROG, 17'h1E004, 16'h1234, 1'b1);
    @(posedge clock) boot_unlock <= 1'b0;
    wr(`FBC_CMD_READ_ARR);
    rdc("prog word", 17'h00020, 16'h0F0F);
    rdc("boot word", 17'h1E004, 16'h1234);
  endtask

  task automatic t_refuse;
    @(posedge clock) supply_ok <= 1'b0;
    do_req(fbc_pkg::FBC_OP_ERASE, PA, 16'h0000, 1'b0);
    check("lock refused", {15'h0000, rf}, 16'h0001);
    check("refuse lat", lat, 16'h0001);
    @(posedge clock) supply_ok <= 1'b1;
    do_req(fbc_pkg::FBC_OP_PROG, 17'h1E008, 16'h0000, 1'b1);
    check("boot refused", {15'h0000, rf}, 16'h0001);
    rdc("boot kept", 17'h1E008, 16'hFFFF);
    wr(8'h00);
    rdc("kept", PA, PD);
  endtask

  task automatic t_erase;
    do_req(fbc_pkg::FBC_OP_ERASE, PA, 16'h0000, 1'b0);
    check("erase ok", {15'h0000, rf}, 16'h0000);
    rdc("erase status", PA, ST);
    wr(`FBC_CMD_READ_ARR);
    rdc("erased", PA, 16'hFFFF);
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    check("cs idle", {15'h0000, chip_sel_n}, 16'h0001);
    rdc("array", PA, PD);
    check("read lat", lat, 16'h0009);
    t_ident();
    t_sleep();
    t_prog();
    t_refuse();
    t_erase();
    wrap_up();
  end
endmodule
